// File: cdt_jtag_host.sv
`timescale 1ns/1ps
// ==========================================================
// jtag host model, one tick per step
module cdt_jtag_host (
  // clock
  input wire logic clk_i,
  // jtag lines
  input wire logic tdo_i,
  output logic tick_o,
  output logic tms_o,
  output logic tdi_o
);
  initial begin
    tick_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // long gap so tdo has settled well before it is read
  task automatic step(input logic m, input logic d, output logic o);
    tick_o <= 1'b1;
    tms_o <= m;
    tdi_o <= d;
    @(posedge clk_i);
    tick_o <= 1'b0;
    // no stale copy between ticks
    tms_o <= ~m;
    tdi_o <= ~d;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    o = tdo_i;
    @(posedge clk_i);
  endtask
endmodule

// File: cdt_pkg.sv
package cdt_pkg;

  // ==========================================================
  // tap controller states (4-bit observable code)
  typedef enum logic [3:0] {
    CDT_TAP_EX2_DR   = 4'h0,
    CDT_TAP_EX1_DR   = 4'h1,
    CDT_TAP_SHIFT_DR = 4'h2,
    CDT_TAP_PAUSE_DR = 4'h3,
    CDT_TAP_SEL_IR   = 4'h4,
    CDT_TAP_UPD_DR   = 4'h5,
    CDT_TAP_CAP_DR   = 4'h6,
    CDT_TAP_SEL_DR   = 4'h7,
    CDT_TAP_EX2_IR   = 4'h8,
    CDT_TAP_EX1_IR   = 4'h9,
    CDT_TAP_SHIFT_IR = 4'hA,
    CDT_TAP_PAUSE_IR = 4'hB,
    CDT_TAP_IDLE     = 4'hC,
    CDT_TAP_UPD_IR   = 4'hD,
    CDT_TAP_CAP_IR   = 4'hE,
    CDT_TAP_RESET    = 4'hF
  } cdt_tap_state_t;

  // ==========================================================
  // instructions, chains, shift lengths
  localparam logic [3:0] CDT_IR_SCAN_N = 4'h2;
  localparam logic [3:0] CDT_IR_RESTART = 4'h4;
  localparam logic [3:0] CDT_IR_INTEST = 4'hC;
  localparam logic [3:0] CDT_IR_IDCODE = 4'hE;
  localparam logic [3:0] CDT_IR_BYPASS = 4'hF;
  localparam logic [3:0] CDT_IR_CAPTURE = 4'h1;
  localparam logic [4:0] CDT_CHAIN_RST = 5'h00;
  localparam logic [4:0] CDT_CHAIN_COMMS = 5'h02;
  localparam logic [4:0] CDT_CHAIN_EXT = 5'h03;
  localparam logic [5:0] CDT_LEN_BYPASS = 6'h01;
  localparam logic [5:0] CDT_LEN_SCAN_N = 6'h05;
  localparam logic [5:0] CDT_LEN_IDCODE = 6'h20;
  localparam logic [5:0] CDT_LEN_COMMS = 6'h21;
  localparam int CDT_DR_W = 33;
  localparam int CDT_COMMS_WR_BIT = 32;

  // ==========================================================
  // synchroniser lanes
  localparam int CDT_SYNC_W = 4;
  localparam int CDT_SI_TICK = 0;
  localparam int CDT_SI_TMS = 1;
  localparam int CDT_SI_TDI = 2;
  localparam int CDT_SI_EHR = 3;

  // ==========================================================
  // register map and fields
  localparam logic [11:0] CDT_OFF_CTRL = 12'h000;
  localparam logic [11:0] CDT_OFF_STATUS = 12'h004;
  localparam logic [11:0] CDT_OFF_TX = 12'h008;
  localparam logic [11:0] CDT_OFF_RX = 12'h00C;
  localparam logic [11:0] CDT_OFF_WP_BASE = 12'h010;
  localparam logic [11:0] CDT_OFF_WP_STRIDE = 12'h010;
  localparam logic [11:0] CDT_OFF_WP_ADDR = 12'h000;
  localparam logic [11:0] CDT_OFF_WP_MASK = 12'h004;
  localparam logic [11:0] CDT_OFF_WP_CTRL = 12'h008;
  localparam int CDT_CTRL_HALT = 1;
  localparam int CDT_STAT_HALTED = 0;
  localparam int CDT_STAT_RX_FULL = 1;
  localparam int CDT_STAT_TX_EMPTY = 2;
  localparam int CDT_STAT_TAP_LSB = 4;
  localparam int CDT_WPC_EN = 0;
  localparam int CDT_WPC_EXT_USE = 1;
  localparam int CDT_WPC_EXT_SEL = 2;
  localparam logic [1:0] CDT_CTRL_RST = 2'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cdt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cdt_apb_rsp_t;

  typedef struct packed {
    logic fetch_done;
    logic pipe_advance;
    logic pipe_flush;
    logic exec_valid;
    logic exec_pass;
    logic data_req_done;
    logic [31:0] addr;
  } cdt_core_t;

endpackage

// File: cdt_top.sv
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module cdt_top #(
  parameter int NUM_WATCH = 2
) (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic debug_reset_n_i,
  // jtag side
  input wire logic debug_tick_enable_i,
  input wire logic debug_tms_i,
  input wire logic debug_tdi_i,
  output logic debug_tdo_o,
  output logic tdo_drive_enable_n_o,
  input wire logic [31:0] jtag_idcode_value_i,
  // observation
  output logic [3:0] tap_instr_observe_o,
  output logic [4:0] scan_chain_select_observe_o,
  output logic [3:0] tap_state_observe_o,
  // external scan chain
  output logic ext_chain_serial_out_o,
  input wire logic ext_chain_serial_return_i,
  // halt control
  input wire logic debug_features_enable_i,
  input wire logic external_halt_request_i,
  output logic internal_halt_request_o,
  output logic halted_ack_o,
  input wire logic external_instr_break_i,
  input wire logic external_data_watch_i,
  input wire logic [1:0] external_match_condition_i,
  // core pipeline
  input wire cdt_pkg::cdt_core_t core_i,
  output logic instr_executed_o,
  output logic [NUM_WATCH-1:0] watch_unit_match_o,
  // comms flags
  output logic comms_rx_full_o,
  output logic comms_tx_empty_o,
  // apb slave
  input wire cdt_pkg::cdt_apb_req_t apb_i,
  output cdt_pkg::cdt_apb_rsp_t apb_o
);

  // ==========================================================
  // state
  typedef struct packed {
    cdt_pkg::cdt_tap_state_t tap;
    logic [3:0] ir_sr;
    logic [3:0] ir;
    logic [4:0] chain;
    logic [cdt_pkg::CDT_DR_W-1:0] dr_sr;
    logic tdo;
    logic tdo_en_n;
    logic ext_out;
    logic [1:0] ctrl;
    logic [31:0] tx_data;
    logic tx_full;
    logic [31:0] rx_data;
    logic rx_full;
    logic dec_tag;
    logic exec_tag;
    logic halted;
    logic halt_req;
    logic exec_out;
    logic [NUM_WATCH-1:0][31:0] wp_addr;
    logic [NUM_WATCH-1:0][31:0] wp_mask;
    logic [NUM_WATCH-1:0][2:0] wp_ctrl;
    logic [NUM_WATCH-1:0] wp_hit;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cdt_state_t;

  cdt_state_t q;
  cdt_state_t n;
  wire logic dbg_rst_n;
  logic [NUM_WATCH-1:0] wp_raw;
  logic [NUM_WATCH-1:0] wp_armed;

  // either reset clears the whole debug block
  assign dbg_rst_n = rst_n_i & debug_reset_n_i;

  // ==========================================================
  // tap transition
  function automatic cdt_pkg::cdt_tap_state_t tap_next(
    input cdt_pkg::cdt_tap_state_t st,
    input logic tms
  );
    case (st)
      cdt_pkg::CDT_TAP_RESET: tap_next = tms ? cdt_pkg::CDT_TAP_RESET : cdt_pkg::CDT_TAP_IDLE;
      cdt_pkg::CDT_TAP_IDLE: tap_next = tms ? cdt_pkg::CDT_TAP_SEL_DR : cdt_pkg::CDT_TAP_IDLE;
      cdt_pkg::CDT_TAP_SEL_DR: tap_next = tms ? cdt_pkg::CDT_TAP_SEL_IR : cdt_pkg::CDT_TAP_CAP_DR;
      cdt_pkg::CDT_TAP_CAP_DR: tap_next = tms ? cdt_pkg::CDT_TAP_EX1_DR : cdt_pkg::CDT_TAP_SHIFT_DR;
      cdt_pkg::CDT_TAP_SHIFT_DR: tap_next = tms ? cdt_pkg::CDT_TAP_EX1_DR : cdt_pkg::CDT_TAP_SHIFT_DR;
      cdt_pkg::CDT_TAP_EX1_DR: tap_next = tms ? cdt_pkg::CDT_TAP_UPD_DR : cdt_pkg::CDT_TAP_PAUSE_DR;
      cdt_pkg::CDT_TAP_PAUSE_DR: tap_next = tms ? cdt_pkg::CDT_TAP_EX2_DR : cdt_pkg::CDT_TAP_PAUSE_DR;
      cdt_pkg::CDT_TAP_EX2_DR: tap_next = tms ? cdt_pkg::CDT_TAP_UPD_DR : cdt_pkg::CDT_TAP_SHIFT_DR;
      cdt_pkg::CDT_TAP_UPD_DR: tap_next = tms ? cdt_pkg::CDT_TAP_SEL_DR : cdt_pkg::CDT_TAP_IDLE;
      cdt_pkg::CDT_TAP_SEL_IR: tap_next = tms ? cdt_pkg::CDT_TAP_RESET : cdt_pkg::CDT_TAP_CAP_IR;
      cdt_pkg::CDT_TAP_CAP_IR: tap_next = tms ? cdt_pkg::CDT_TAP_EX1_IR : cdt_pkg::CDT_TAP_SHIFT_IR;
      cdt_pkg::CDT_TAP_SHIFT_IR: tap_next = tms ? cdt_pkg::CDT_TAP_EX1_IR : cdt_pkg::CDT_TAP_SHIFT_IR;
      cdt_pkg::CDT_TAP_EX1_IR: tap_next = tms ? cdt_pkg::CDT_TAP_UPD_IR : cdt_pkg::CDT_TAP_PAUSE_IR;
      cdt_pkg::CDT_TAP_PAUSE_IR: tap_next = tms ? cdt_pkg::CDT_TAP_EX2_IR : cdt_pkg::CDT_TAP_PAUSE_IR;
      cdt_pkg::CDT_TAP_EX2_IR: tap_next = tms ? cdt_pkg::CDT_TAP_UPD_IR : cdt_pkg::CDT_TAP_SHIFT_IR;
      cdt_pkg::CDT_TAP_UPD_IR: tap_next = tms ? cdt_pkg::CDT_TAP_SEL_DR : cdt_pkg::CDT_TAP_IDLE;
      default: tap_next = cdt_pkg::CDT_TAP_RESET;
    endcase
  endfunction

  // ==========================================================
  // watch units
  for (genvar g = 0; g < NUM_WATCH; g++) begin : g_wp
    // ext condition is an extra qualifying term, never a match on its own
    assign wp_raw[g] = core_i.data_req_done
      && (((core_i.addr ^ q.wp_addr[g]) & ~q.wp_mask[g]) == 32'h0000_0000)
      && (!q.wp_ctrl[g][cdt_pkg::CDT_WPC_EXT_USE]
          || external_match_condition_i[q.wp_ctrl[g][cdt_pkg::CDT_WPC_EXT_SEL]]);
    assign wp_armed[g] = wp_raw[g] && q.wp_ctrl[g][cdt_pkg::CDT_WPC_EN];
  end

  // ==========================================================
  // next state
  always_comb begin
    logic tick;
    logic tms;
    logic tdi;
    logic [5:0] dr_len;
    logic ext_sel;
    logic setup;
    logic access;
    logic hit;
    logic [31:0] rd;
    logic [11:0] wbase;
    logic req_int;
    logic enter;
    tick = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    dr_len = cdt_pkg::CDT_LEN_BYPASS;
    ext_sel = 1'b0;
    setup = 1'b0;
    access = 1'b0;
    hit = 1'b0;
    rd = 32'h0000_0000;
    wbase = 12'h000;
    req_int = 1'b0;
    enter = 1'b0;
    n = q;

    // debug pins come from the core clock domain; a filter would eat one-cycle ticks
    tick = debug_tick_enable_i;
    tms = debug_tms_i;
    tdi = debug_tdi_i;

    // data register selection by active instruction
    ext_sel = (q.ir == cdt_pkg::CDT_IR_INTEST) && (q.chain == cdt_pkg::CDT_CHAIN_EXT);
    case (q.ir)
      cdt_pkg::CDT_IR_SCAN_N: dr_len = cdt_pkg::CDT_LEN_SCAN_N;
      cdt_pkg::CDT_IR_IDCODE: dr_len = cdt_pkg::CDT_LEN_IDCODE;
      cdt_pkg::CDT_IR_INTEST: begin
        if (q.chain == cdt_pkg::CDT_CHAIN_COMMS) begin
          dr_len = cdt_pkg::CDT_LEN_COMMS;
        end
      end
      default: dr_len = cdt_pkg::CDT_LEN_BYPASS;
    endcase

    n.tdo_en_n = !((q.tap == cdt_pkg::CDT_TAP_SHIFT_DR)
                || (q.tap == cdt_pkg::CDT_TAP_SHIFT_IR));

    // ---------------- tap, only on qualified edges
    if (tick) begin
      n.tap = tap_next(q.tap, tms);
      case (q.tap)
        cdt_pkg::CDT_TAP_RESET: begin
          n.ir = cdt_pkg::CDT_IR_IDCODE;
        end
        cdt_pkg::CDT_TAP_CAP_IR: begin
          n.ir_sr = cdt_pkg::CDT_IR_CAPTURE;
        end
        cdt_pkg::CDT_TAP_SHIFT_IR: begin
          n.tdo = q.ir_sr[0];
          n.ir_sr = {tdi, q.ir_sr[3:1]};
        end
        cdt_pkg::CDT_TAP_UPD_IR: begin
          n.ir = q.ir_sr;
        end
        cdt_pkg::CDT_TAP_CAP_DR: begin
          n.dr_sr = '0;
          case (q.ir)
            cdt_pkg::CDT_IR_SCAN_N: n.dr_sr[4:0] = q.chain;
            cdt_pkg::CDT_IR_IDCODE: n.dr_sr[31:0] = jtag_idcode_value_i;
            cdt_pkg::CDT_IR_INTEST: n.dr_sr = {q.tx_full, q.tx_data};
            default: n.dr_sr = '0;
          endcase
        end
        cdt_pkg::CDT_TAP_SHIFT_DR: begin
          n.tdo = ext_sel ? ext_chain_serial_return_i : q.dr_sr[0];
          n.ext_out = tdi;
          n.dr_sr = q.dr_sr >> 1;
          n.dr_sr[dr_len - 6'h01] = tdi;
        end
        cdt_pkg::CDT_TAP_UPD_DR: begin
          if (q.ir == cdt_pkg::CDT_IR_SCAN_N) begin
            n.chain = q.dr_sr[4:0];
          end
          if ((q.ir == cdt_pkg::CDT_IR_INTEST) && (q.chain == cdt_pkg::CDT_CHAIN_COMMS)) begin
            if (q.dr_sr[cdt_pkg::CDT_COMMS_WR_BIT]) begin
              n.rx_data = q.dr_sr[31:0];
            end else begin
              n.tx_full = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ---------------- apb slave, one setup plus one access cycle
    setup = apb_i.psel && !apb_i.penable;
    access = apb_i.psel && apb_i.penable && q.pready;
    case (apb_i.paddr)
      cdt_pkg::CDT_OFF_CTRL: begin
        hit = 1'b1;
        rd[1:0] = q.ctrl;
      end
      cdt_pkg::CDT_OFF_STATUS: begin
        hit = 1'b1;
        rd[cdt_pkg::CDT_STAT_HALTED] = q.halted;
        rd[cdt_pkg::CDT_STAT_RX_FULL] = q.rx_full;
        rd[cdt_pkg::CDT_STAT_TX_EMPTY] = !q.tx_full;
        rd[cdt_pkg::CDT_STAT_TAP_LSB +: 4] = q.tap;
      end
      cdt_pkg::CDT_OFF_TX: begin
        hit = 1'b1;
        rd = q.tx_data;
      end
      cdt_pkg::CDT_OFF_RX: begin
        hit = 1'b1;
        rd = q.rx_data;
      end
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < NUM_WATCH; i++) begin
      wbase = cdt_pkg::CDT_OFF_WP_BASE + cdt_pkg::CDT_OFF_WP_STRIDE * 12'(i);
      if (apb_i.paddr == wbase + cdt_pkg::CDT_OFF_WP_ADDR) begin
        hit = 1'b1;
        rd = q.wp_addr[i];
        if (access && apb_i.pwrite) begin
          n.wp_addr[i] = apb_i.pwdata;
        end
      end
      if (apb_i.paddr == wbase + cdt_pkg::CDT_OFF_WP_MASK) begin
        hit = 1'b1;
        rd = q.wp_mask[i];
        if (access && apb_i.pwrite) begin
          n.wp_mask[i] = apb_i.pwdata;
        end
      end
      if (apb_i.paddr == wbase + cdt_pkg::CDT_OFF_WP_CTRL) begin
        hit = 1'b1;
        rd[2:0] = q.wp_ctrl[i];
        if (access && apb_i.pwrite) begin
          n.wp_ctrl[i] = apb_i.pwdata[2:0];
        end
      end
    end
    n.pready = setup;
    n.pslverr = setup && !hit;
    n.prdata = (setup && hit && !apb_i.pwrite) ? rd : 32'h0000_0000;
    if (access && apb_i.pwrite && (apb_i.paddr == cdt_pkg::CDT_OFF_CTRL)) begin
      n.ctrl = apb_i.pwdata[1:0];
    end
    // core reads host data: clear first so a same-cycle host write wins
    if (access && !apb_i.pwrite && (apb_i.paddr == cdt_pkg::CDT_OFF_RX)) begin
      n.rx_full = 1'b0;
    end
    if (tick && (q.tap == cdt_pkg::CDT_TAP_UPD_DR) && (q.ir == cdt_pkg::CDT_IR_INTEST)
        && (q.chain == cdt_pkg::CDT_CHAIN_COMMS) && q.dr_sr[cdt_pkg::CDT_COMMS_WR_BIT]) begin
      n.rx_full = 1'b1;
    end
    // a full transmit buffer is not overwritten; the new word is dropped
    if (access && apb_i.pwrite && (apb_i.paddr == cdt_pkg::CDT_OFF_TX) && !q.tx_full) begin
      n.tx_data = apb_i.pwdata;
      n.tx_full = 1'b1;
    end

    // ---------------- halt logic
    req_int = external_halt_request_i | q.ctrl[cdt_pkg::CDT_CTRL_HALT];
    n.halt_req = req_int;
    if (core_i.pipe_flush) begin
      n.dec_tag = 1'b0;
      n.exec_tag = 1'b0;
    end else begin
      if (core_i.pipe_advance) begin
        n.exec_tag = q.dec_tag;
      end
      if (core_i.fetch_done) begin
        n.dec_tag = external_instr_break_i;
      end else if (core_i.pipe_advance) begin
        n.dec_tag = 1'b0;
      end
    end
    enter = req_int
         || (q.exec_tag && core_i.exec_valid && !core_i.pipe_flush)
         || (external_data_watch_i && core_i.data_req_done)
         || (|wp_armed);
    if (tick && (q.tap == cdt_pkg::CDT_TAP_IDLE) && (q.ir == cdt_pkg::CDT_IR_RESTART)) begin
      n.halted = 1'b0;
    end
    if (enter) begin
      n.halted = 1'b1;
    end
    if (!debug_features_enable_i) begin
      n.halted = 1'b0;
    end
    n.exec_out = core_i.exec_valid && core_i.exec_pass;
    n.wp_hit = wp_raw;
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      q <= '0;
      q.tap <= cdt_pkg::CDT_TAP_RESET;
      q.ir <= cdt_pkg::CDT_IR_IDCODE;
      q.chain <= cdt_pkg::CDT_CHAIN_RST;
      q.ctrl <= cdt_pkg::CDT_CTRL_RST;
      q.tdo_en_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign debug_tdo_o = q.tdo;
  assign tdo_drive_enable_n_o = q.tdo_en_n;
  assign tap_instr_observe_o = q.ir;
  assign scan_chain_select_observe_o = q.chain;
  assign tap_state_observe_o = q.tap;
  assign ext_chain_serial_out_o = q.ext_out;
  assign internal_halt_request_o = q.halt_req;
  assign halted_ack_o = q.halted;
  assign instr_executed_o = q.exec_out;
  assign watch_unit_match_o = q.wp_hit;
  assign comms_rx_full_o = q.rx_full;
  assign comms_tx_empty_o = !q.tx_full;
  assign apb_o.prdata = q.prdata;
  assign apb_o.pready = q.pready;
  assign apb_o.pslverr = q.pslverr;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!dbg_rst_n);

  a_ir_obs_update: assert property ($changed(tap_instr_observe_o) |->
    ($past(q.tap) == cdt_pkg::CDT_TAP_UPD_IR) || ($past(q.tap) == cdt_pkg::CDT_TAP_RESET))
    else $error("instruction observe changed outside update-IR");
  a_chain_obs_update: assert property ($changed(scan_chain_select_observe_o) |->
    ($past(q.tap) == cdt_pkg::CDT_TAP_UPD_DR) && ($past(q.ir) == cdt_pkg::CDT_IR_SCAN_N))
    else $error("chain select changed outside update-DR");
  a_tdo_en_shift: assert property ((tap_state_observe_o == cdt_pkg::CDT_TAP_SHIFT_DR)
    |=> !tdo_drive_enable_n_o)
    else $error("tdo enable not low while shifting");
  a_tdo_en_idle: assert property ((tap_state_observe_o == cdt_pkg::CDT_TAP_IDLE)
    |=> tdo_drive_enable_n_o)
    else $error("tdo enable low outside shift");
  a_tap_tick_hold: assert property (!debug_tick_enable_i
    |=> $stable(tap_state_observe_o))
    else $error("tap moved without tick");
  a_tap_five_ones: assert property ((debug_tick_enable_i && debug_tms_i)
    [*5] |=> (tap_state_observe_o == cdt_pkg::CDT_TAP_RESET))
    else $error("five tms ones did not reach reset");
  a_rx_set_cause: assert property ($rose(comms_rx_full_o) |->
    ($past(q.tap) == cdt_pkg::CDT_TAP_UPD_DR))
    else $error("rx flag rose without host update");
  a_tx_fill: assert property ((apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite
    && (apb_i.paddr == cdt_pkg::CDT_OFF_TX)) |=> !comms_tx_empty_o)
    else $error("tx flag still empty after write");
  a_req_or: assert property ((external_halt_request_i || q.ctrl[cdt_pkg::CDT_CTRL_HALT])
    |=> internal_halt_request_o)
    else $error("internal request missing");
  a_halt_on_req: assert property ((debug_features_enable_i && internal_halt_request_o)
    |=> halted_ack_o)
    else $error("no halt after request");
  a_gate_off: assert property (!debug_features_enable_i |=> !halted_ack_o)
    else $error("halted while debug disabled");
  a_dwatch_halt: assert property ((debug_features_enable_i && external_data_watch_i
    && core_i.data_req_done) |=> halted_ack_o)
    else $error("data watch did not halt");
  a_exec_pulse: assert property ((core_i.exec_valid && core_i.exec_pass)
    |=> instr_executed_o)
    else $error("executed pulse missing");

endmodule

// File: cdt_top_bench.sv
`timescale 1ns/1ps
module cdt_top_bench;
  // ==========================================================
  // signals
  logic ref_clk_i, rst_n_i, dbg_rst_n, dbg_en, ehr, tick, tms, tdi, tdo_w, so;
  logic en_n, hreq, hack, iexec, rxf, txe;
  logic [3:0] instr, st;
  logic [1:0] wum;
  logic [31:0] idv, seed = 32'h0000_7D73;
  logic [33:0] e;
  cdt_pkg::cdt_core_t core, cv;
  cdt_pkg::cdt_apb_req_t req;
  cdt_pkg::cdt_apb_rsp_t rsp;
  int err_total, checks_done, cyc;
  logic [33:0] exp_q[$];

  cdt_top cdt_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .debug_reset_n_i(dbg_rst_n),
    .debug_tick_enable_i(tick), .debug_tms_i(tms), .debug_tdi_i(tdi), .debug_tdo_o(tdo_w),
    .tdo_drive_enable_n_o(en_n), .jtag_idcode_value_i(idv), .tap_instr_observe_o(instr),
    .scan_chain_select_observe_o(), .tap_state_observe_o(st), .ext_chain_serial_out_o(),
    .ext_chain_serial_return_i(1'b0),
    .debug_features_enable_i(dbg_en), .external_halt_request_i(ehr),
    .internal_halt_request_o(hreq), .halted_ack_o(hack), .external_instr_break_i(1'b0),
    .external_data_watch_i(1'b0), .external_match_condition_i(2'h0), .core_i(core),
    .instr_executed_o(iexec), .watch_unit_match_o(wum), .comms_rx_full_o(rxf),
    .comms_tx_empty_o(txe), .apb_i(req), .apb_o(rsp));
  cdt_jtag_host cdt_jtag_host_i (.clk_i(ref_clk_i), .tdo_i(tdo_w), .tick_o(tick),
    .tms_o(tms), .tdi_o(tdi));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t(input logic m, input logic d, input logic [3:0] s);
    cdt_jtag_host_i.step(m, d, so);
    chk("tap state", s, st);
  endtask
  task automatic ir(input logic [3:0] v, input logic [3:0] old);
    t(1'b1, 1'b0, cdt_pkg::CDT_TAP_SEL_DR);
    t(1'b1, 1'b0, cdt_pkg::CDT_TAP_SEL_IR);
    t(1'b0, 1'b0, cdt_pkg::CDT_TAP_CAP_IR);
    t(1'b0, 1'b0, cdt_pkg::CDT_TAP_SHIFT_IR);
    for (int i = 0; i < 4; i++) begin
      t(i == 3, v[i], (i == 3) ? cdt_pkg::CDT_TAP_EX1_IR : cdt_pkg::CDT_TAP_SHIFT_IR);
      chk("ir capture", i == 0, so);
    end
    chk("instr held", old, instr);
    t(1'b1, 1'b0, cdt_pkg::CDT_TAP_UPD_IR);
    t(1'b0, 1'b0, cdt_pkg::CDT_TAP_IDLE);
    chk("instr", v, instr);
  endtask
  // setup, then access until pready; release only after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    exp_q.push_back({w, x});
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    @(posedge ref_clk_i);
    while (rsp.pready !== 1'b1) @(posedge ref_clk_i);
    req <= '0;
    @(posedge ref_clk_i);
  endtask

  // ==========================================================
  // clock, watchdog, apb monitor
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("apb error", e[32], rsp.pslverr);
      if (!e[33]) chk("apb rdata", e[31:0], rsp.prdata);
    end
  end

  // ==========================================================
  // sequence
  initial begin
    rst_n_i = 1'b0;
    dbg_rst_n = 1'b1;
    dbg_en = 1'b1;
    ehr = 1'b0;
    core = '0;
    req = '0;
    idv = rnd();
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("reset outs", 13'h1FD2, {st, instr, txe, rxf, hack, en_n, hreq});
    @(posedge ref_clk_i);
    t(1'b0, 1'b0, cdt_pkg::CDT_TAP_IDLE);
    repeat (20) @(posedge ref_clk_i);
    chk("no tick", cdt_pkg::CDT_TAP_IDLE, st);
    ir(cdt_pkg::CDT_IR_BYPASS, cdt_pkg::CDT_IR_IDCODE);
    dbg_rst_n <= 1'b0;
    @(negedge ref_clk_i);
    chk("debug reset", 8'hFE, {st, instr});
    @(posedge ref_clk_i);
    dbg_rst_n <= 1'b1;
    t(1'b0, 1'b0, cdt_pkg::CDT_TAP_IDLE);
    t(1'b1, 1'b0, cdt_pkg::CDT_TAP_SEL_DR);
    t(1'b0, 1'b0, cdt_pkg::CDT_TAP_CAP_DR);
    t(1'b0, 1'b0, cdt_pkg::CDT_TAP_SHIFT_DR);
    for (int i = 0; i < 32; i++) begin
      t(i == 31, 1'b0, (i == 31) ? cdt_pkg::CDT_TAP_EX1_DR : cdt_pkg::CDT_TAP_SHIFT_DR);
      chk("id bit", idv[i], so);
      chk("tdo enable", i == 31, en_n);
    end
    $display("done jtag");
    apb(1'b1, 12'h000, 32'h2, 33'h0);
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("halt", 2'h3, {hreq, hack});
    @(posedge ref_clk_i);
    apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0015);
    apb(1'b1, 12'h000, 32'h0, 33'h0);
    apb(1'b0, 12'h0FC, 32'h0, 33'h1_0000_0000);
    dbg_en <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk("gated", 1'b0, hack);
    ehr <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    chk("gated request", 2'h2, {hreq, hack});
    dbg_en <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("external halt", 1'b1, hack);
    ehr <= 1'b0;
    dbg_en <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    dbg_en <= 1'b1;
    $display("done halt");
    apb(1'b1, 12'h014, 32'hFFFF_FFFF, 33'h0);
    repeat (24) begin
      cv = 38'({rnd(), rnd()});
      core <= cv;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("executed", cv.exec_valid & cv.exec_pass, iexec);
      chk("watch match", {cv.data_req_done && (cv.addr == 32'h0), cv.data_req_done}, wum);
      @(posedge ref_clk_i);
    end
    $display("done execute");
    summarize();
  end
endmodule
